// File: src/cvsf_pkg.sv
// Purpose: Shared constants for the converter status and fault register bank.
// Assumes: Registers sit one per 32-bit word at byte address four times the parameter id.
// Notes: Identifier words are printed ids; byte addresses derive from them.
package cvsf_pkg;
    // ------------------------------------------------------------------
    // Parameter identifiers and address width
    // ------------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam logic [15:0] PID_FAULT_RESET = 16'h0006;
    localparam logic [15:0] PID_PASSWORD = 16'h0007;
    localparam logic [15:0] PID_CFG_RESET = 16'h0008;
    localparam logic [15:0] PID_CFG_RELOAD = 16'h0009;
    localparam logic [15:0] PID_OP_STATE = 16'h4000;
    localparam logic [15:0] PID_GRID_I_A = 16'h4006;
    localparam logic [15:0] PID_GRID_I_B = 16'h4007;
    localparam logic [15:0] PID_GRID_I_C = 16'h4008;
    localparam logic [15:0] PID_LOOP_LOCK = 16'h400b;
    localparam logic [15:0] PID_INV_A_TEMP = 16'h400c;
    localparam logic [15:0] PID_AUX_TEMP = 16'h400d;
    localparam logic [15:0] PID_CONTACTOR = 16'h400e;
    localparam logic [15:0] PID_WARNING = 16'h400f;
    localparam logic [15:0] PID_FAULT_PRI = 16'h4010;
    localparam logic [15:0] PID_RESULT = 16'h4011;
    localparam logic [15:0] PID_INV_A_I_A = 16'h4017;
    localparam logic [15:0] PID_INV_A_I_B = 16'h4018;
    localparam logic [15:0] PID_INV_A_I_C = 16'h4019;
    localparam logic [15:0] PID_INV_B_I_A = 16'h401a;
    localparam logic [15:0] PID_INV_B_I_B = 16'h401b;
    localparam logic [15:0] PID_INV_B_I_C = 16'h401c;
    localparam logic [15:0] PID_INV_B_TEMP = 16'h401d;
    localparam logic [15:0] PID_FAULT_OVL = 16'h401e;
    localparam logic [15:0] PID_ISO_INPUT = 16'h401f;
    // ------------------------------------------------------------------
    // Field layouts and reserved-bit masks
    // ------------------------------------------------------------------
    localparam int LOCK_BIT = 0;
    localparam int LINE_CONT_BIT = 0;
    localparam int PRECH_CONT_BIT = 1;
    localparam int ISO_W = 4;
    localparam logic [31:0] WARN_MASK = 32'hf87fff80;
    localparam logic [31:0] FAULT_PRI_MASK = 32'h07ffffff;
    localparam logic [31:0] FAULT_OVL_MASK = 32'h0000003f;
    // ------------------------------------------------------------------
    // Command values and result codes
    // ------------------------------------------------------------------
    localparam logic [31:0] CMD_NOP = 32'h00000000;
    localparam logic [31:0] CMD_GO = 32'h00000001;
    localparam logic [15:0] PASSWORD_DEFAULT = 16'h1111;
    localparam logic [15:0] RES_OK = 16'h0000;
    localparam logic [15:0] RES_BAD_ID = 16'h0001;
    localparam logic [15:0] RES_WR_RO = 16'h0002;
    localparam logic [15:0] RES_RD_WO = 16'h0003;
    localparam logic [15:0] RES_RANGE = 16'h0004;
    localparam logic [15:0] RES_MEM_HW = 16'h0005;
    localparam logic [15:0] RES_MEM_CRC = 16'h0006;
    localparam logic [15:0] RES_PASSWORD = 16'h0007;
    localparam logic [15:0] RES_RUNNING = 16'h0008;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    // ------------------------------------------------------------------
    // Controller states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CVSF_STANDBY = 3'b001,
        CVSF_RUN = 3'b010,
        CVSF_FAULT = 3'b100
    } cvsf_state_e;
endpackage : cvsf_pkg

// File: src/cvsf_latch.sv
// Purpose: Word of sticky flags that hardware sets and a command clears.
// Assumes: Set and clear are synchronous to the clock.
// Notes: A set arriving with the clear wins, so no event is lost.
`timescale 1ns/1ns
`default_nettype none
module cvsf_latch #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] set_i,
    input wire logic clear_i,
    output logic [W-1:0] flags_q
);
    // ------------------------------------------------------------------
    // Sticky storage
    // ------------------------------------------------------------------
    logic [W-1:0] flags_d;

    // Hold each bit until cleared, and let a fresh set override the clear.
    assign flags_d = (clear_i ? '0 : flags_q) | set_i;

    // Flag register.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_q <= '0;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end
endmodule : cvsf_latch
`default_nettype wire

// File: src/cvsf_status_bank.sv
// Purpose: Read-only status and fault register bank of a grid converter controller.
// Assumes: All inputs are synchronous to ref_clk; host uses Avalon-MM with waitrequest.
// Notes: Every access answers in two cycles; the result register follows each access.
// Overview of operation
// - Grid current is sum of enabled inverters.
// - Single inverter: grid current equals inverter A.
// - Loop lock in bit 0, rest zero.
// - Auxiliary temperature zero without external sensor.
// - Line contactor bit 0, precharge bit 1.
// - Warning bit is one while present.
// - Warning bits 7 to 13 map inverter A.
// - Warning bits 14 to 22 grid, inverter B.
// - Bits 23-26 reserved; 27-31 supply tolerances.
// - Fault bits latch until fault reset written, or until input three rises with on/off enabled.
// - Any fault forces fault state, stops converter.
// - Fault word one bits 0 to 7.
// - Fault word one bits 8 to 19.
// - Fault word one bits 20 to 26.
// - Fault word two overload bits 0 to 5.
// - Result register updated after every access.
// - Result codes 0 to 4 meanings.
// - Result codes 5 to 8 meanings.
// - Single inverter: inverter B currents read zero.
// - Inverter B temperature zero unless dual operation.
// - Four isolated inputs in low bits.
// - Inputs may be dedicated to contactor, on/off.
// - Fault reset clears latches, self-clears, returns standby.
// - Reload or reset refused while running.
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module cvsf_status_bank
    import cvsf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic dual_inverter_en,
    input wire logic aux_sensor_en,
    input wire logic contactor_monitor_en,
    input wire logic hw_onoff_en,
    input wire logic run_request,
    input wire logic [15:0] inv_a_current_a,
    input wire logic [15:0] inv_a_current_b,
    input wire logic [15:0] inv_a_current_c,
    input wire logic [15:0] inv_b_current_a,
    input wire logic [15:0] inv_b_current_b,
    input wire logic [15:0] inv_b_current_c,
    input wire logic [15:0] inv_a_temp,
    input wire logic [15:0] inv_b_temp,
    input wire logic [15:0] aux_temp,
    input wire logic loop_locked,
    input wire logic line_contactor_closed,
    input wire logic precharge_contactor_closed,
    input wire logic [31:0] warning_cond,
    input wire logic [31:0] fault_primary_evt,
    input wire logic [31:0] fault_overload_evt,
    input wire logic iso_input_zero,
    input wire logic iso_input_one,
    input wire logic iso_input_two,
    input wire logic iso_input_three,
    output logic converter_run,
    output logic fault_active,
    output logic [2:0] ctrl_state,
    output logic [3:0] gp_inputs,
    output logic cfg_reload_pulse,
    output logic cfg_reset_pulse
);
    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    logic ack_q;
    logic ack_d;
    logic req;
    logic done;
    logic wr_done;
    logic [15:0] parameter_identifier;

    // A request waits one cycle while read data are captured, then completes.
    assign req = avs_read | avs_write;
    assign ack_d = req & ~ack_q;
    assign avs_waitrequest = req & ~ack_q;
    assign done = req & ack_q;
    assign wr_done = avs_write & ack_q;
    assign parameter_identifier = {1'b0, avs_address[ADDR_W-1:2]};

    // Handshake register.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= ack_d;
        end
    end

    // ------------------------------------------------------------------
    // Measurement views that depend on inverter and auxiliary sensor configuration
    // ------------------------------------------------------------------
    logic [15:0] grid_a;
    logic [15:0] grid_b;
    logic [15:0] grid_c;
    logic [15:0] inv_b_a_view;
    logic [15:0] inv_b_b_view;
    logic [15:0] inv_b_c_view;
    logic [15:0] inv_b_temp_view;
    logic [15:0] aux_temp_view;

    // Inverter B figures only count, and only show, in dual operation.
    assign inv_b_a_view = dual_inverter_en ? inv_b_current_a : 16'h0000;
    assign inv_b_b_view = dual_inverter_en ? inv_b_current_b : 16'h0000;
    assign inv_b_c_view = dual_inverter_en ? inv_b_current_c : 16'h0000;
    assign inv_b_temp_view = dual_inverter_en ? inv_b_temp : 16'h0000;
    assign aux_temp_view = aux_sensor_en ? aux_temp : 16'h0000;

    // Grid current is the wrapping sum of enabled inverters; B adds zero when single.
    assign grid_a = 16'(inv_a_current_a + inv_b_a_view);
    assign grid_b = 16'(inv_a_current_b + inv_b_b_view);
    assign grid_c = 16'(inv_a_current_c + inv_b_c_view);

    // ------------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------------
    logic [15:0] lock_word;
    logic [15:0] contactor_word;
    logic [31:0] warning_word;
    logic [15:0] iso_word;

    // Reserved bits read as zero; warnings are live, never latched.
    assign lock_word = {15'h0000, loop_locked};
    assign contactor_word = {14'h0000, precharge_contactor_closed, line_contactor_closed};
    assign warning_word = warning_cond & WARN_MASK;
    assign iso_word = {12'h000, iso_input_three, iso_input_two, iso_input_one,
        iso_input_zero};

    // Inputs taken for contactor or on/off duty drop out of general use.
    assign gp_inputs = iso_word[ISO_W-1:0]
        & {~hw_onoff_en, ~hw_onoff_en, ~contactor_monitor_en, ~contactor_monitor_en};

    // ------------------------------------------------------------------
    // Latched fault words
    // ------------------------------------------------------------------
    logic [31:0] fault_pri_q;
    logic [31:0] fault_ovl_q;
    logic [31:0] fault_pri_set;
    logic [31:0] fault_ovl_set;
    logic fault_clear;

    // Only documented fault positions can ever latch.
    assign fault_pri_set = fault_primary_evt & FAULT_PRI_MASK;
    assign fault_ovl_set = fault_overload_evt & FAULT_OVL_MASK;

    // Primary fault word.
    cvsf_latch #(
        .W(32)
    ) u_fault_pri (
        .clk(ref_clk),
        .rst_n(rst_n),
        .set_i(fault_pri_set),
        .clear_i(fault_clear),
        .flags_q(fault_pri_q)
    );

    // Overload fault word.
    cvsf_latch #(
        .W(32)
    ) u_fault_ovl (
        .clk(ref_clk),
        .rst_n(rst_n),
        .set_i(fault_ovl_set),
        .clear_i(fault_clear),
        .flags_q(fault_ovl_q)
    );

    // ------------------------------------------------------------------
    // Command decode and access result
    // ------------------------------------------------------------------
    logic [15:0] password_q;
    logic [15:0] password_d;
    logic [15:0] result_q;
    logic [15:0] result_d;
    logic hw_reset_q;
    logic hw_reset_edge;
    logic sw_reset;
    logic is_cmd;
    logic is_readable;
    logic val_ok;
    logic running;
    logic pw_ok;
    logic [15:0] wr_code;
    logic [15:0] rd_code;

    // Readable ids are the instrumentation set; command ids are write-only.
    assign is_readable = (parameter_identifier >= PID_OP_STATE) && (parameter_identifier <= PID_ISO_INPUT);
    assign is_cmd = (parameter_identifier >= PID_FAULT_RESET) && (parameter_identifier <= PID_CFG_RELOAD);
    assign val_ok = (avs_writedata == CMD_NOP) || (avs_writedata == CMD_GO);
    assign pw_ok = (password_q == PASSWORD_DEFAULT);
    assign running = converter_run;

    // Result of a read: success, write-only id, or unknown id.
    assign rd_code = is_readable ? RES_OK : (is_cmd ? RES_RD_WO : RES_BAD_ID);

    // Result of a write, range first, then run state, then password.
    assign wr_code = is_readable ? RES_WR_RO :
        !is_cmd ? RES_BAD_ID :
        (parameter_identifier == PID_PASSWORD) ? RES_OK :
        !val_ok ? RES_RANGE :
        (avs_writedata != CMD_GO || parameter_identifier == PID_FAULT_RESET) ? RES_OK :
        running ? RES_RUNNING :
        (parameter_identifier == PID_CFG_RESET && !pw_ok) ? RES_PASSWORD : RES_OK;

    // Commands act once, on the completing edge, only when accepted.
    assign sw_reset = wr_done && parameter_identifier == PID_FAULT_RESET && avs_writedata == CMD_GO;
    assign hw_reset_edge = hw_onoff_en & iso_input_three & ~hw_reset_q;
    assign fault_clear = sw_reset | hw_reset_edge;
    assign result_d = !done ? result_q : (avs_write ? wr_code : rd_code);

    // Password is consumed by the access after the one that loads it.
    assign password_d = (wr_done && parameter_identifier == PID_PASSWORD) ? avs_writedata[15:0] :
        (done ? 16'h0000 : password_q);

    // Result, password and hardware reset edge registers.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_q <= RESULT_RESET;
            password_q <= 16'h0000;
            hw_reset_q <= 1'b1; // A pin already high at release is not an edge.
        end
        else
        begin
            result_q <= result_d;
            password_q <= password_d;
            hw_reset_q <= iso_input_three;
        end
    end

    // Configuration commands pulse only when not refused.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_reload_pulse <= 1'b0;
            cfg_reset_pulse <= 1'b0;
        end
        else
        begin
            cfg_reload_pulse <= wr_done && parameter_identifier == PID_CFG_RELOAD && wr_code == RES_OK
                && avs_writedata == CMD_GO;
            cfg_reset_pulse <= wr_done && parameter_identifier == PID_CFG_RESET && wr_code == RES_OK
                && avs_writedata == CMD_GO;
        end
    end

    // ------------------------------------------------------------------
    // Controller state
    // ------------------------------------------------------------------
    cvsf_state_e state_q;
    cvsf_state_e state_d;
    logic any_fault;
    logic new_fault;
    logic want_run;

    // A latched or arriving fault holds the controller in its fault state.
    assign new_fault = (|fault_pri_set) | (|fault_ovl_set);
    assign any_fault = new_fault | (|fault_pri_q) | (|fault_ovl_q);
    assign want_run = hw_onoff_en ? iso_input_two : run_request;

    // Next state.
    always_comb
    begin
        case (state_q)
            CVSF_STANDBY: state_d = any_fault ? CVSF_FAULT :
                (want_run ? CVSF_RUN : CVSF_STANDBY);
            CVSF_RUN: state_d = any_fault ? CVSF_FAULT :
                (want_run ? CVSF_RUN : CVSF_STANDBY);
            CVSF_FAULT: state_d = (fault_clear && !new_fault) ? CVSF_STANDBY
                : CVSF_FAULT;
            default: state_d = CVSF_FAULT;
        endcase
    end

    // State register.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= CVSF_STANDBY;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Run stops at once in the fault state.
    assign converter_run = (state_q == CVSF_RUN);
    assign fault_active = (state_q == CVSF_FAULT);
    assign ctrl_state = state_q;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    logic [31:0] rdata_q;

    // Select the word addressed by the request; unknown ids read zero.
    always_comb
    begin
        case (parameter_identifier)
            PID_GRID_I_A: rd_mux = {16'h0000, grid_a};
            PID_GRID_I_B: rd_mux = {16'h0000, grid_b};
            PID_GRID_I_C: rd_mux = {16'h0000, grid_c};
            PID_LOOP_LOCK: rd_mux = {16'h0000, lock_word};
            PID_INV_A_TEMP: rd_mux = {16'h0000, inv_a_temp};
            PID_AUX_TEMP: rd_mux = {16'h0000, aux_temp_view};
            PID_CONTACTOR: rd_mux = {16'h0000, contactor_word};
            PID_WARNING: rd_mux = warning_word;
            PID_FAULT_PRI: rd_mux = fault_pri_q;
            PID_RESULT: rd_mux = {16'h0000, result_q};
            PID_INV_A_I_A: rd_mux = {16'h0000, inv_a_current_a};
            PID_INV_A_I_B: rd_mux = {16'h0000, inv_a_current_b};
            PID_INV_A_I_C: rd_mux = {16'h0000, inv_a_current_c};
            PID_INV_B_I_A: rd_mux = {16'h0000, inv_b_a_view};
            PID_INV_B_I_B: rd_mux = {16'h0000, inv_b_b_view};
            PID_INV_B_I_C: rd_mux = {16'h0000, inv_b_c_view};
            PID_INV_B_TEMP: rd_mux = {16'h0000, inv_b_temp_view};
            PID_FAULT_OVL: rd_mux = fault_ovl_q;
            PID_ISO_INPUT: rd_mux = {16'h0000, iso_word};
            PID_OP_STATE: rd_mux = {29'h00000000, state_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Capture read data in the waiting cycle so it stands at completion.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 32'h00000000;
        end
        else if (avs_read && !ack_q)
        begin
            rdata_q <= rd_mux;
        end
    end

    assign avs_readdata = rdata_q;
endmodule : cvsf_status_bank
`default_nettype wire

// File: verif/cvsf_status_bank_checker.sv
// Purpose: Concurrent checks on the status bank ports.
// Assumes: Inputs stay steady while a read is pending.
// Notes: Bound to every instance of the bank.
`timescale 1ns/1ns
`default_nettype none
module cvsf_status_checker
    import cvsf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic dual_inverter_en,
    input wire logic hw_onoff_en,
    input wire logic [15:0] inv_a_current_a,
    input wire logic [15:0] inv_b_current_a,
    input wire logic loop_locked,
    input wire logic line_contactor_closed,
    input wire logic precharge_contactor_closed,
    input wire logic [31:0] warning_cond,
    input wire logic [31:0] fault_primary_evt,
    input wire logic converter_run,
    input wire logic fault_active,
    input wire logic cfg_reload_pulse
);
    // -----------------------------------------------------------------
    // Completed transfers and the word they target.
    // -----------------------------------------------------------------
    wire logic rd_ok = avs_read & ~avs_waitrequest;
    wire logic wr_ok = avs_write & ~avs_waitrequest;
    wire logic [14:0] parameter_identifier = avs_address[ADDR_W-1:2];
    wire logic clr = wr_ok && parameter_identifier == PID_FAULT_RESET[14:0] && avs_writedata == CMD_GO;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_lock;
        rd_ok && parameter_identifier == PID_LOOP_LOCK[14:0] |-> avs_readdata == {31'h0, $past(loop_locked)}; endproperty
    a_lock: assert property (p_lock) else $error("lock word wrong");
    property p_cont;
        rd_ok && parameter_identifier == PID_CONTACTOR[14:0] |-> avs_readdata ==
            {30'h0, $past(precharge_contactor_closed), $past(line_contactor_closed)}; endproperty
    a_cont: assert property (p_cont) else $error("contactor word wrong");
    property p_warn;
        rd_ok && parameter_identifier == PID_WARNING[14:0] |-> avs_readdata == ($past(warning_cond) & WARN_MASK); endproperty
    a_warn: assert property (p_warn) else $error("warning word wrong");
    property p_sum;
        rd_ok && parameter_identifier == PID_GRID_I_A[14:0] |-> avs_readdata ==
            {16'h0, $past(inv_a_current_a + (dual_inverter_en ? inv_b_current_a : 16'h0))}; endproperty
    a_sum: assert property (p_sum) else $error("grid current wrong");
    property p_invb;
        rd_ok && !$past(dual_inverter_en) && (parameter_identifier == PID_INV_B_I_A[14:0] ||
            parameter_identifier == PID_INV_B_TEMP[14:0]) |-> avs_readdata == 32'h0; endproperty
    a_invb: assert property (p_invb) else $error("inverter b not zero");
    property p_fault;
        |(fault_primary_evt & FAULT_PRI_MASK) |-> ##[1:2] (fault_active && !converter_run); endproperty
    a_fault: assert property (p_fault) else $error("no fault state");
    property p_stay;
        fault_active && !hw_onoff_en && !clr && !$past(clr) |=> fault_active; endproperty
    a_stay: assert property (p_stay) else $error("fault state left early");
    property p_pulse;
        cfg_reload_pulse |-> $past(wr_ok && parameter_identifier == PID_CFG_RELOAD[14:0] && !converter_run); endproperty
    a_pulse: assert property (p_pulse) else $error("reload pulse unexpected");
endmodule : cvsf_status_checker
bind cvsf_status_bank cvsf_status_checker cvsf_status_checker_i (.*);
`default_nettype wire

// File: verif/cvsf_host_model.sv
// Purpose: Host master issuing parameter reads and writes.
// Assumes: One transfer at a time, called from the bench.
// Notes: Released address and data show the inverse of their last value.
`timescale 1ns/1ns
`default_nettype none
module cvsf_host_model
    import cvsf_pkg::*;
(
    input wire logic ref_clk,
    output logic [ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    // Idle bus at time zero.
    initial
    begin
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
    end
    // One transfer, held until waitrequest is low at an edge.
    task automatic acc(input logic w, input logic [15:0] parameter_identifier, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge ref_clk);
        avs_address <= {parameter_identifier[ADDR_W-3:0], 2'b00};
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= d;
        do
            @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~avs_address;
        avs_writedata <= ~avs_writedata;
    endtask : acc
endmodule : cvsf_host_model
`default_nettype wire

// File: verif/test_converter_status_fault_registers.sv
// Purpose: Self-checking bench for the status and fault bank.
// Assumes: Host model runs the bus; bench drives the plant side.
// Notes: Phase b and c currents and inverter a temperature stay fixed.
`timescale 1ns/1ns
`default_nettype none
module test_converter_status_fault_registers
    import cvsf_pkg::*;
;
    logic ref_clk = 1'b0, rst_n = 1'b0, avs_read, avs_write, avs_waitrequest;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdat;
    logic dual_inverter_en = 1'b0, aux_sensor_en = 1'b0, contactor_monitor_en = 1'b0;
    logic hw_onoff_en = 1'b0, run_request = 1'b0, loop_locked = 1'b1;
    logic [15:0] inv_a_current_a = 16'h0100, inv_b_current_a = 16'h0020;
    logic [15:0] inv_a_current_b = 16'h0011, inv_a_current_c = 16'h0012;
    logic [15:0] inv_b_current_b = 16'h0013, inv_b_current_c = 16'h0014;
    logic [15:0] inv_a_temp = 16'h0022, inv_b_temp = 16'h0033, aux_temp = 16'h0044;
    logic line_contactor_closed = 1'b1, precharge_contactor_closed = 1'b0;
    logic [31:0] warning_cond = 32'hffffffff, fault_primary_evt = '0, fault_overload_evt = '0;
    logic iso_input_zero = 1'b0, iso_input_one = 1'b1, iso_input_two = 1'b0;
    logic iso_input_three = 1'b1, converter_run, fault_active, cfg_reload_pulse, cfg_reset_pulse;
    logic [2:0] ctrl_state;
    logic [3:0] gp_inputs;
    int n_mismatch = 0, total_checks = 0, n_pulse = 0;
    cvsf_status_bank cvsf_status_bank_i (.*);
    cvsf_host_model cvsf_host_model_i (.*);
    // Clock source.
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end
    // Counts accepted configuration commands.
    always @(posedge ref_clk)
        n_pulse += int'(cfg_reload_pulse === 1'b1) + int'(cfg_reset_pulse === 1'b1);
    // Cuts a hang short.
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        results();
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input logic [15:0] parameter_identifier, input logic [31:0] exp);
        cvsf_host_model_i.acc(1'b0, parameter_identifier, 32'h0, rdat);
        chk(rdat, exp);
    endtask : rd
    task automatic res(input logic w, input logic [15:0] parameter_identifier, input logic [31:0] d,
        input logic [15:0] c);
        cvsf_host_model_i.acc(w, parameter_identifier, d, rdat);
        rd(PID_RESULT, {16'h0, c});
    endtask : res
    task results;
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // Main sequence: single inverter, dual inverter, result codes, faults.
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(PID_LOOP_LOCK, 32'h1);
        rd(PID_CONTACTOR, 32'h1);
        rd(PID_WARNING, WARN_MASK);
        rd(PID_RESULT, 32'h0);
        rd(PID_GRID_I_A, 32'h100);
        rd(PID_INV_A_I_A, 32'h100);
        rd(PID_INV_B_I_A, 32'h0);
        rd(PID_INV_B_TEMP, 32'h0);
        rd(PID_AUX_TEMP, 32'h0);
        rd(PID_ISO_INPUT, 32'ha);
        dual_inverter_en <= 1'b1;
        aux_sensor_en <= 1'b1;
        loop_locked <= 1'b0;
        line_contactor_closed <= 1'b0;
        precharge_contactor_closed <= 1'b1;
        warning_cond <= 32'h0;
        contactor_monitor_en <= 1'b1;
        rd(PID_GRID_I_A, 32'h120);
        rd(PID_INV_B_TEMP, 32'h33);
        rd(PID_AUX_TEMP, 32'h44);
        rd(PID_WARNING, 32'h0);
        rd(PID_LOOP_LOCK, 32'h0);
        rd(PID_CONTACTOR, 32'h2);
        chk({28'h0, gp_inputs}, 32'h8);
        res(1'b1, PID_WARNING, 32'h0, RES_WR_RO);
        res(1'b0, 16'h3000, 32'h0, RES_BAD_ID);
        res(1'b0, PID_FAULT_RESET, 32'h0, RES_RD_WO);
        res(1'b1, PID_FAULT_RESET, 32'h2, RES_RANGE);
        run_request <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({31'h0, converter_run}, 32'h1);
        res(1'b1, PID_CFG_RELOAD, CMD_GO, RES_RUNNING);
        fault_primary_evt <= 32'h84080181;
        fault_overload_evt <= 32'h80000020;
        @(posedge ref_clk);
        fault_primary_evt <= 32'h0;
        fault_overload_evt <= 32'h0;
        repeat (2) @(posedge ref_clk);
        chk({29'h0, ctrl_state}, {29'h0, CVSF_FAULT});
        chk({31'h0, converter_run}, 32'h0);
        rd(PID_FAULT_PRI, 32'h04080181);
        rd(PID_FAULT_OVL, 32'h20);
        run_request <= 1'b0;
        res(1'b1, PID_FAULT_RESET, CMD_GO, RES_OK);
        rd(PID_FAULT_PRI, 32'h0);
        chk({29'h0, ctrl_state}, {29'h0, CVSF_STANDBY});
        res(1'b1, PID_CFG_RESET, CMD_GO, RES_PASSWORD);
        cvsf_host_model_i.acc(1'b1, PID_PASSWORD, {16'h0, PASSWORD_DEFAULT}, rdat);
        res(1'b1, PID_CFG_RESET, CMD_GO, RES_OK);
        res(1'b1, PID_CFG_RELOAD, CMD_GO, RES_OK);
        chk(n_pulse, 32'h2);
        hw_onoff_en <= 1'b1;
        @(posedge ref_clk);
        chk({28'h0, gp_inputs}, 32'h0);
        fault_overload_evt <= 32'h1;
        iso_input_three <= 1'b0;
        @(posedge ref_clk);
        fault_overload_evt <= 32'h0;
        @(posedge ref_clk);
        chk({29'h0, ctrl_state}, {29'h0, CVSF_FAULT});
        iso_input_three <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({29'h0, ctrl_state}, {29'h0, CVSF_STANDBY});
        results();
    end
endmodule : test_converter_status_fault_registers
`default_nettype wire
